// ---- smp_defs.vh ----
// Purpose: Shared constants of the serial memory pin front end.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only; no logic lives here.
`ifndef SMP_DEFS_VH
`define SMP_DEFS_VH

// Lane modes of the data path.
`define SMP_MODE_W        2
`define SMP_MODE_SINGLE   2'h0
`define SMP_MODE_DUAL     2'h1
`define SMP_MODE_QUAD     2'h2

// Bits moved per serial clock edge in each mode.
`define SMP_STEP_SINGLE   3'h1
`define SMP_STEP_DUAL     3'h2
`define SMP_STEP_QUAD     3'h4

// One-hot states of the select tracker.
`define SMP_ST_W          3
`define SMP_ST_RST        3'h1
`define SMP_ST_STBY       3'h2
`define SMP_ST_ACT        3'h4

// Synchroniser lanes and their positions.
`define SMP_NSYNC         6
`define SMP_SYNC_RST      6'h3f
`define SMP_IX_CS         0
`define SMP_IX_SCK        1
`define SMP_IX_IO0        2
`define SMP_IX_IO1        3
`define SMP_IX_IO2        4
`define SMP_IX_IO3        5

// Byte and bit counter layout.
`define SMP_BYTE_W        8
`define SMP_CNT_W         3
`define SMP_CNT_ZERO      3'h0
`define SMP_BYTE_ZERO     8'h00

`endif

// ---- smp_sync.v ----
// Purpose: Two flip-flop synchroniser for pin inputs, one lane per bit.
// Assumes: Lanes are independent levels from outside the clk domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`include "smp_defs.vh"

module smp_sync
#(
  parameter W = `SMP_NSYNC
)
(
  clk,
  arst_n,
  async_in,
  sync_out
);
  input  wire         clk;
  input  wire         arst_n;
  input  wire [W-1:0] async_in;
  output wire [W-1:0] sync_out;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_lane
      reg meta_q;
      reg stab_q;
      // Lanes idle high so a released reset does not look like a select or clock edge.
      always @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          meta_q <= 1'b1;
          stab_q <= 1'b1;
        end
        else
        begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate
endmodule

// ---- smp_pin_if.v ----
// Purpose: Pin-level front end of a serial memory target on a single, dual or quad SPI bus.
// Assumes: clk at 125 MHz oversamples the serial clock; arst_n is the hardware reset pin.
// Notes:   Opcode decoding, registers and the array sit in other blocks behind the user ports.
`timescale 1ns/1ns
`include "smp_defs.vh"

// Operation
// - Chip select is active low.
// - Select high: standby, inputs ignored, outputs tristated.
// - Serial clock used only while selected.
// - Sample on rising, drive on falling edge.
// - Fully static, clock may stop anytime.
// - Output driven only for read data.
// - Line zero bidirectional in dual/quad.
// - Line one bidirectional in dual/quad.
// - Lines two, three bidirectional in quad.
// - Protect low plus disable bit blocks writes.
// - Reset low reinitialises internal state.
// - After reset: standby or active by select.
// - Revert to single lane on deselect/reset.
module smp_pin_if
(
  clk,
  arst_n,
  cs_n,
  sck,
  bidir_line_zero_i,
  bidir_line_zero_o,
  bidir_line_zero_oe,
  bidir_line_one_i,
  bidir_line_one_o,
  bidir_line_one_oe,
  bidir_line_two_i,
  bidir_line_two_o,
  bidir_line_two_oe,
  bidir_line_three_i,
  bidir_line_three_o,
  bidir_line_three_oe,
  mode_load,
  mode_sel,
  soft_reset,
  drive_req,
  tx_byte,
  tx_take,
  rx_valid,
  rx_byte,
  status_write_disable_bit,
  reg_wr_req,
  reg_wr_ok,
  reg_wr_reject,
  lane_mode,
  standby,
  active
);
  input  wire                  clk;
  input  wire                  arst_n;
  input  wire                  cs_n;
  input  wire                  sck;
  input  wire                  bidir_line_zero_i;
  output reg                   bidir_line_zero_o;
  output reg                   bidir_line_zero_oe;
  input  wire                  bidir_line_one_i;
  output reg                   bidir_line_one_o;
  output reg                   bidir_line_one_oe;
  input  wire                  bidir_line_two_i;
  output reg                   bidir_line_two_o;
  output reg                   bidir_line_two_oe;
  input  wire                  bidir_line_three_i;
  output reg                   bidir_line_three_o;
  output reg                   bidir_line_three_oe;
  input  wire                  mode_load;
  input  wire [`SMP_MODE_W-1:0] mode_sel;
  input  wire                  soft_reset;
  input  wire                  drive_req;
  input  wire [`SMP_BYTE_W-1:0] tx_byte;
  output reg                   tx_take;
  output reg                   rx_valid;
  output reg  [`SMP_BYTE_W-1:0] rx_byte;
  input  wire                  status_write_disable_bit;
  input  wire                  reg_wr_req;
  output wire                  reg_wr_ok;
  output wire                  reg_wr_reject;
  output wire [`SMP_MODE_W-1:0] lane_mode;
  output wire                  standby;
  output wire                  active;

  wire [`SMP_NSYNC-1:0] pins_s;
  reg                   sck_prev_q;
  reg [`SMP_ST_W-1:0]   state_q;
  reg [`SMP_ST_W-1:0]   state_d;
  reg [`SMP_MODE_W-1:0] mode_q;
  reg [`SMP_CNT_W-1:0]  rx_cnt_q;
  reg [`SMP_BYTE_W-1:0] rx_sh_q;
  reg [`SMP_CNT_W-1:0]  tx_cnt_q;
  reg [`SMP_BYTE_W-1:0] tx_sh_q;
  reg [`SMP_CNT_W-1:0]  step;
  reg [`SMP_BYTE_W-1:0] rx_next;
  reg [`SMP_BYTE_W-1:0] tx_cur;

  wire cs_s   = pins_s[`SMP_IX_CS];
  wire sck_s  = pins_s[`SMP_IX_SCK];
  wire sel    = ~cs_s & state_q[2];
  wire sck_en = sel;
  wire rise   = sck_en & sck_s & ~sck_prev_q;
  wire fall   = sck_en & ~sck_s & sck_prev_q;
  wire driving = bidir_line_one_oe | bidir_line_zero_oe;

  // The pins come from the host's domain, so every one is synchronised first.
  smp_sync #(.W(`SMP_NSYNC)) u_sync
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({bidir_line_three_i, bidir_line_two_i, bidir_line_one_i, bidir_line_zero_i, sck, cs_n}),
    .sync_out (pins_s)
  );

  assign lane_mode = mode_q;
  assign standby   = state_q[1];
  assign active    = state_q[2];

  // Protect input only exists as such while the line is not a quad data lane.
  wire wp_low = ~pins_s[`SMP_IX_IO2] & (mode_q != `SMP_MODE_QUAD);
  assign reg_wr_reject = reg_wr_req & wp_low & status_write_disable_bit;
  assign reg_wr_ok     = reg_wr_req & ~reg_wr_reject;

  always @*
  begin
    case (mode_q)
      `SMP_MODE_DUAL:
      begin
        step    = `SMP_STEP_DUAL;
        rx_next = {rx_sh_q[5:0], pins_s[`SMP_IX_IO1], pins_s[`SMP_IX_IO0]};
      end
      `SMP_MODE_QUAD:
      begin
        step    = `SMP_STEP_QUAD;
        rx_next = {rx_sh_q[3:0], pins_s[`SMP_IX_IO3], pins_s[`SMP_IX_IO2],
                   pins_s[`SMP_IX_IO1], pins_s[`SMP_IX_IO0]};
      end
      default:
      begin
        step    = `SMP_STEP_SINGLE;
        rx_next = {rx_sh_q[6:0], pins_s[`SMP_IX_IO0]};
      end
    endcase
    tx_cur = (tx_cnt_q == `SMP_CNT_ZERO) ? tx_byte : tx_sh_q;
  end

  // Reset is released into a decision state so the select level is read by a clocked process.
  always @*
  begin
    case (state_q)
      `SMP_ST_RST:  state_d = cs_s ? `SMP_ST_STBY : `SMP_ST_ACT;
      `SMP_ST_STBY: state_d = cs_s ? `SMP_ST_STBY : `SMP_ST_ACT;
      `SMP_ST_ACT:  state_d = cs_s ? `SMP_ST_STBY : `SMP_ST_ACT;
      default:      state_d = `SMP_ST_RST;
    endcase
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q    <= `SMP_ST_RST;
      sck_prev_q <= 1'b1;
      mode_q     <= `SMP_MODE_SINGLE;
    end
    else
    begin
      state_q    <= state_d;
      sck_prev_q <= sck_s;
      if (cs_s | soft_reset)
        mode_q <= `SMP_MODE_SINGLE;
      else if (mode_load & sel)
        mode_q <= mode_sel;
    end
  end

  // Receive path: inputs are taken only on rising edges and only while not driving.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_cnt_q <= `SMP_CNT_ZERO;
      rx_sh_q  <= `SMP_BYTE_ZERO;
      rx_byte  <= `SMP_BYTE_ZERO;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!sel)
        rx_cnt_q <= `SMP_CNT_ZERO;
      else if (rise && !driving)
      begin
        rx_sh_q  <= rx_next;
        rx_cnt_q <= rx_cnt_q + step;
        if (rx_cnt_q + step == `SMP_CNT_ZERO)
        begin
          rx_byte  <= rx_next;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // Transmit path: while selected, enables and data change only on falling edges, so the host, which
  // releases the lines after its last rising edge, never fights the device.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_cnt_q            <= `SMP_CNT_ZERO;
      tx_sh_q             <= `SMP_BYTE_ZERO;
      tx_take             <= 1'b0;
      bidir_line_zero_o   <= 1'b0;
      bidir_line_one_o    <= 1'b0;
      bidir_line_two_o    <= 1'b0;
      bidir_line_three_o  <= 1'b0;
      bidir_line_zero_oe  <= 1'b0;
      bidir_line_one_oe   <= 1'b0;
      bidir_line_two_oe   <= 1'b0;
      bidir_line_three_oe <= 1'b0;
    end
    else
    begin
      tx_take <= 1'b0;
      if (!sel)
      begin
        tx_cnt_q            <= `SMP_CNT_ZERO;
        bidir_line_zero_oe  <= 1'b0;
        bidir_line_one_oe   <= 1'b0;
        bidir_line_two_oe   <= 1'b0;
        bidir_line_three_oe <= 1'b0;
      end
      else if (fall)
      begin
        bidir_line_one_oe   <= drive_req;
        bidir_line_zero_oe  <= drive_req & (mode_q != `SMP_MODE_SINGLE);
        bidir_line_two_oe   <= drive_req & (mode_q == `SMP_MODE_QUAD);
        bidir_line_three_oe <= drive_req & (mode_q == `SMP_MODE_QUAD);
        if (drive_req)
        begin
          tx_take  <= (tx_cnt_q == `SMP_CNT_ZERO);
          tx_cnt_q <= tx_cnt_q + step;
          case (mode_q)
            `SMP_MODE_DUAL:
            begin
              bidir_line_one_o  <= tx_cur[7];
              bidir_line_zero_o <= tx_cur[6];
              tx_sh_q           <= {tx_cur[5:0], 2'h0};
            end
            `SMP_MODE_QUAD:
            begin
              bidir_line_three_o <= tx_cur[7];
              bidir_line_two_o   <= tx_cur[6];
              bidir_line_one_o   <= tx_cur[5];
              bidir_line_zero_o  <= tx_cur[4];
              tx_sh_q            <= {tx_cur[3:0], 4'h0};
            end
            default:
            begin
              bidir_line_one_o <= tx_cur[7];
              tx_sh_q          <= {tx_cur[6:0], 1'b0};
            end
          endcase
        end
        else
          tx_cnt_q <= `SMP_CNT_ZERO;
      end
    end
  end
endmodule

// ---- smp_pin_if_checker.sv ----
// Purpose: Concurrent checks on the pin front end.
// Assumes: Bound into smp_pin_if; clk oversamples sck.
// Notes:   Six-cycle windows cover the input synchroniser.
`timescale 1ns/1ns
`include "smp_defs.vh"
module smp_pin_if_checker
(
  input wire       clk,
  input wire       arst_n,
  input wire       cs_n,
  input wire       sck,
  input wire       bidir_line_zero_oe,
  input wire       bidir_line_one_o,
  input wire       bidir_line_one_oe,
  input wire       bidir_line_two_i,
  input wire       bidir_line_two_oe,
  input wire       bidir_line_three_oe,
  input wire       status_write_disable_bit,
  input wire       reg_wr_req,
  input wire       reg_wr_ok,
  input wire       reg_wr_reject,
  input wire [1:0] lane_mode,
  input wire       standby,
  input wire       active,
  input wire       rx_valid,
  input wire       tx_take
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire any_oe = bidir_line_zero_oe | bidir_line_one_oe | bidir_line_two_oe | bidir_line_three_oe;
  a_idle_tristate:
    assert property (cs_n [*6] |-> !any_oe && standby) else $error("line driven while deselected");
  a_select_active:
    assert property (!cs_n [*6] |-> active && !standby) else $error("not active while selected");
  a_mode_revert:
    assert property (cs_n [*6] |-> lane_mode == `SMP_MODE_SINGLE) else $error("lane mode kept");
  a_reset_init:
    assert property ($rose(arst_n) |-> !any_oe && lane_mode == 2'h0) else $error("state after reset");
  a_wr_reject:
    assert property (reg_wr_reject == (reg_wr_req && !$past(bidir_line_two_i, 2) && status_write_disable_bit
      && lane_mode != `SMP_MODE_QUAD)) else $error("protect decision wrong");
  a_wr_ok:
    assert property (reg_wr_ok == (reg_wr_req && !reg_wr_reject)) else $error("write grant wrong");
  a_turn_on_fall:
    assert property ($rose(bidir_line_one_oe) |-> !sck && !$past(sck, 2)) else $error("turn not on fall");
  a_out_steady:
    assert property (bidir_line_one_oe && sck && $past(sck) |-> $stable(bidir_line_one_o))
      else $error("output moved while clock high");
  c_rx: cover property (rx_valid);
  c_tx: cover property (tx_take);
  c_rej: cover property (reg_wr_reject);
endmodule
bind smp_pin_if smp_pin_if_checker i_chk (.*);

// ---- smp_host_model.sv ----
// Purpose: Host controller model driving select, clock and the data lines.
// Assumes: Clock mode 0 with a 125 ns period.
// Notes:   Line zero is inverted on every select change so no stale level lingers.
`timescale 1ns/1ns
module smp_host_model
(
  output logic cs_n,
  output logic sck,
  output logic       d0,
  output logic [3:1] hq,
  output logic       hq_en,
  input  wire        d1
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    d0 = 1'b0;
    hq = 3'h0;
    hq_en = 1'b0;
  end
  // Quad input cycles: the host drives all four lines, highest nibble first.
  task automatic xfer4(input logic [7:0] tx);
    hq_en = 1'b1;
    for (int i = 1; i >= 0; i--)
    begin
      {hq, d0} = tx[i*4 +: 4];
      #62 sck = 1'b1;
      #63 sck = 1'b0;
    end
    hq_en = 1'b0;
  endtask
  // Data changes while the clock is low, captured at each rise.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      d0 = tx[i];
      #62 sck = 1'b1;
      rx[i] = d1;
      #63 sck = 1'b0;
    end
  endtask
  // Each opcode gets a fresh select.
  task automatic sel(input logic on);
    #63 cs_n = !on;
    d0 = ~d0;
  endtask
endmodule

// ---- test_smp_pin_if.sv ----
// Purpose: Self-checking bench for the pin front end.
// Assumes: Host model stands on the pins.
// Notes:   Inputs move on the falling clk edge.
`timescale 1ns/1ns
module test_smp_pin_if;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       wp_n = 1'b1;
  logic       mode_load = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic       soft_reset = 1'b0;
  logic       drive_req = 1'b0;
  logic [7:0] tx_byte = 8'h3c;
  logic       swd = 1'b0;
  logic       wr_req = 1'b0;
  logic [7:0] rd;
  logic [3:0] nib_hi;
  logic [3:0] nib_lo;
  wire  [3:1] hq;
  wire        hq_en;
  int         failures = 0;
  int         compares = 0;
  wire        cs_n, sck, d0, o0, oe0, o1, oe1, o2, oe2, o3, oe3, take, rxv, ok, rej, stby, act;
  wire [7:0]  rxb;
  wire [1:0]  lane;
  wire        i1 = oe1 ? o1 : (hq_en ? hq[1] : ~o1);
  always #4 clk = ~clk;
  smp_host_model i_host (.cs_n(cs_n), .sck(sck), .d0(d0), .hq(hq), .hq_en(hq_en), .d1(i1));
  smp_pin_if i_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
    .bidir_line_zero_i(oe0 ? o0 : d0), .bidir_line_zero_o(o0), .bidir_line_zero_oe(oe0),
    .bidir_line_one_i(i1), .bidir_line_one_o(o1), .bidir_line_one_oe(oe1),
    .bidir_line_two_i(oe2 ? o2 : (hq_en ? hq[2] : wp_n)), .bidir_line_two_o(o2), .bidir_line_two_oe(oe2),
    .bidir_line_three_i(oe3 ? o3 : (hq_en ? hq[3] : ~o3)), .bidir_line_three_o(o3), .bidir_line_three_oe(oe3),
    .mode_load(mode_load), .mode_sel(mode_sel), .soft_reset(soft_reset), .drive_req(drive_req),
    .tx_byte(tx_byte), .tx_take(take), .rx_valid(rxv), .rx_byte(rxb),
    .status_write_disable_bit(swd), .reg_wr_req(wr_req), .reg_wr_ok(ok), .reg_wr_reject(rej),
    .lane_mode(lane), .standby(stby), .active(act));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wait_rx;
    int n;
    n = 0;
    while (rxv !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (rxv !== 1'b1)
    begin
      failures++;
      results;
    end
  endtask
  task s_protect;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      {wp_n, swd} = i[1:0];
      wr_req = 1'b1;
      repeat (3) @(negedge clk);
      check(rej, {7'h0, !wp_n && swd});
      check(ok, {7'h0, !(!wp_n && swd)});
    end
    wr_req = 1'b0;
    wp_n = 1'b1;
  endtask
  task s_read;
    i_host.sel(1'b1);
    fork
      i_host.xfer(8'ha5, rd);
      begin
        wait_rx;
        drive_req = 1'b1;
      end
    join
    check(rxb, 8'ha5);
    i_host.xfer(8'h00, rd);
    check(rd, 8'h3c);
    @(negedge clk);
    drive_req = 1'b0;
    i_host.sel(1'b0);
    repeat (10) @(negedge clk);
    check(oe1, 8'h0);
  endtask
  task s_mode;
    i_host.sel(1'b1);
    repeat (5) @(negedge clk);
    for (int m = 1; m < 3; m++)
    begin
      @(negedge clk);
      soft_reset = 1'b0;
      check(lane, 8'h0);
      mode_sel = m[1:0];
      mode_load = 1'b1;
      @(negedge clk);
      mode_load = 1'b0;
      @(negedge clk);
      check(lane, m[7:0]);
      soft_reset = m == 1;
    end
    @(negedge clk);
    soft_reset = 1'b0;
    i_host.sel(1'b0);
    repeat (10) @(negedge clk);
    check(lane, 8'h0);
  endtask
  task s_quad;
    i_host.sel(1'b1);
    repeat (5) @(negedge clk);
    mode_sel = 2'h2;
    mode_load = 1'b1;
    tx_byte = 8'h96;
    @(negedge clk);
    mode_load = 1'b0;
    i_host.xfer4(8'h5a);
    check(rxb, 8'h5a);
    @(negedge clk);
    drive_req = 1'b1;
    fork
      i_host.xfer(8'h00, rd);
      begin
        @(posedge sck);
        nib_hi = {o3, o2, o1, o0};
        check({oe3, oe2, oe1, oe0}, 8'hf);
        @(posedge sck);
        nib_lo = {o3, o2, o1, o0};
      end
    join
    check({nib_hi, nib_lo}, 8'h96);
    @(negedge clk);
    drive_req = 1'b0;
    i_host.sel(1'b0);
    repeat (10) @(negedge clk);
    check({oe3, oe2, oe1, oe0, 2'h0, lane}, 8'h0);
  endtask
  task s_reset;
    i_host.sel(1'b1);
    @(negedge clk);
    arst_n = 1'b0;
    @(negedge clk);
    check(oe1, 8'h0);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    check(act, 8'h1);
    i_host.sel(1'b0);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    check({stby, act, lane}, 8'h8);
    s_protect;
    s_read;
    s_mode;
    s_quad;
    s_reset;
    results;
  end
endmodule
